// *** verilog/clk_rst_params.svh ***
// Offsets, reset values, field positions and timing counts of the clock and reset block
`ifndef CLK_RST_PARAMS_SVH
`define CLK_RST_PARAMS_SVH
`define OFF_MAIN_CLOCK_CONTROL 8'h00
`define OFF_RC_TRIM_HIGH       8'h04
`define OFF_INTEGRITY_CONTROL  8'h08
`define OFF_PLL_TEST_REG       8'h0C
`define OFF_SEQ_STATUS         8'h10
`define RST_MAIN_CLOCK_CONTROL 8'h00
`define RST_RC_TRIM_HIGH       8'hFF
`define RST_TRIM_LOWER_BITS    2'h3
`define RST_PLL_HALVE          1'b0
`define BIT_SLOW_SELECT        0
`define BIT_CLOCK_OUT_ENABLE   1
`define BIT_LOCKED             3
`define POS_TRIM_LO            5
`define BIT_PLL_HALVE          7
`define SLOW_DIV               6'd32
`define DELAY_SHORT            13'd256
`define DELAY_LONG             13'd4096
`define FETCH_CYCLES           2'd2
`define PLL_START_NS           10000
`define CLK_PERIOD_NS          50
`define PLL_START_CYC          ((`PLL_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_ADDR_FIRST         16'hDEE0
`define RESET_VECTOR_ADDR      16'hFFFE
`endif

// *** verilog/clk_rst_pkg.sv ***
// Types for the clock and reset sequencer
package clk_rst_pkg;
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_DELAY  = 3'b001,
    ST_PLL    = 3'b010,
    ST_FETCH  = 3'b011,
    ST_RUN    = 3'b100
  } seq_state_t;
  typedef enum logic [1:0] {
    SRC_RC      = 2'b00,
    SRC_EXT     = 2'b01,
    SRC_CRYSTAL = 2'b10
  } clk_src_t;
  typedef struct packed {
    clk_src_t   src;
    logic       pll_on;
    logic       pll_x8;
    logic       icc38;
    logic       icc35;
  } options_t;
  typedef struct packed {
    logic       wdg;
    logic       low_voltage_detector;
    logic       illegal_op;
  } rst_req_t;
endpackage

// *** verilog/clock_and_reset_sequencer.sv ***
// Clock selection, RC trim and reset sequencing with an AHB-Lite register slave
// Function
// - Ten-bit RC trim from trim register and integrity control bits 6:5.
// - RC trim register returns to FFh on every reset.
// - Trim 00h gives highest frequency, FFh lowest; passed monotonically.
// - Calibration bytes DEE0h-DEE3h stay readable whatever erase happened.
// - Stored low trim bits sit at positions 6:5 of calibration bytes.
// - 38-pulse programming entry forces RC; 35-pulse uses tool clock.
// - Option bits enable PLL with x4 or x8 from 1 MHz input.
// - No PLL: RC gives 1 MHz; neither RC nor PLL: external clock.
// - PLL withholds its clock for a startup delay after reset or wake.
// - Lock bit set by hardware when PLL reaches operating frequency.
// - PLL halve bit divides PLL output by two.
// - Bit 1 enables clock output pin; cleared frees it; reset clears.
// - Bit 0 selects CPU clock osc or osc/32; reset clears.
// - Crystal oscillator keeps running throughout reset.
// - Resets from pin, low-voltage detector, watchdog, illegal opcode.
// - Reset pin driven low during whole delay phase.
// - Reset vector fetched from FFFEh-FFFFh at sequence end.
// - Delay 256 cycles for RC or external, 4096 for crystal.
// - Vector fetch lasts two cycles; PLL startup added when enabled.
// - External low pulse detected asynchronously, even in halt.
// - PLL halve at bit 7 of PLL test register, RW, reset clears.
`timescale 1ns/10ps
`include "clk_rst_params.svh"
module clock_and_reset_sequencer (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  hready,
  input  wire clk_rst_pkg::options_t opts,
  input  wire clk_rst_pkg::rst_req_t reqs,
  input  wire logic                  halt_wake,
  input  wire logic                  pll_at_freq,
  input  wire logic                  rst_pin_i,
  output logic                       rst_pin_o,
  output logic                       rst_pin_oe,
  output logic [9:0]                 rc_trim,
  output logic                       osc_rc_sel,
  output logic                       osc_pll_sel,
  output logic                       pll_enable,
  output logic                       pll_mult8,
  output logic                       pll_halve_o,
  output logic                       crystal_run,
  output logic                       cpu_clk_en,
  output logic                       clock_out_enable,
  output logic                       core_reset_n,
  output logic                       vec_fetch,
  output logic [15:0]                vec_addr,
  input  wire logic [1:0]            cal_sel,
  output logic [7:0]                 cal_byte
);
  import clk_rst_pkg::*;

  logic [7:0]  main_ctl_q;
  logic [7:0]  trim_hi_q;
  logic [1:0]  trim_lo_q;
  logic        pll_halve_q;
  logic        locked_q;
  logic        pin_s1_q, pin_s2_q;
  logic        req_s1_q, req_s2_q;
  logic        pin_low_q;
  seq_state_t  state_q;
  logic [12:0] cnt_q;
  logic [12:0] delay_len;
  logic [15:0] pll_cnt_q;
  logic [4:0]  div_q;
  logic        slow_q;
  logic        wr_q;
  logic [7:0]  wa_q;
  logic        any_src;
  logic [7:0]  cal_rom [0:3];
  logic [7:0]  rd_mux;
  logic        seq_done_q;
  logic        enter_pll;
  logic        ext_low_n;

  // Factory calibration bytes, separate from erasable memory; and
  assign cal_rom[0] = 8'h80;
  assign cal_rom[1] = {1'b0, 2'h2, 5'h00};
  assign cal_rom[2] = 8'h80;
  assign cal_rom[3] = {1'b0, 2'h2, 5'h00};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_byte <= 8'h00;
    end else begin
      cal_byte <= cal_rom[cal_sel];
    end
  end

  // Own drive masked, so the device never retriggers itself; and
  assign ext_low_n = rst_pin_i | rst_pin_oe;
  // Pin low latch caught asynchronously, then synchronised
  always_ff @(posedge hclk or negedge ext_low_n) begin
    if (!ext_low_n) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Internal sources synchronised
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_s1_q <= 1'b1;
      req_s2_q <= 1'b1;
    end else begin
      req_s1_q <= reqs.wdg | reqs.low_voltage_detector | reqs.illegal_op;
      req_s2_q <= req_s1_q;
    end
  end
  assign pin_low_q = pin_s2_q;
  assign any_src   = pin_low_q | req_s2_q | !hresetn;

  // Delay length from option clock source
  assign delay_len = (opts.src == SRC_CRYSTAL && !opts.icc38) ? `DELAY_LONG : `DELAY_SHORT;

  // Reset sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= ST_ACTIVE;
      cnt_q     <= 13'd0;
      pll_cnt_q <= 16'd0;
    end else if (any_src) begin
      state_q   <= ST_ACTIVE;
      cnt_q     <= 13'd0;
      pll_cnt_q <= 16'd0;
    end else begin
      case (state_q)
        ST_ACTIVE: begin
          state_q <= ST_DELAY;
          cnt_q   <= 13'd0;
        end
        ST_DELAY: begin
          if (cpu_clk_en) begin
            cnt_q <= cnt_q + 13'd1;
            if (cnt_q == delay_len - 13'd1) begin
              state_q <= pll_enable ? ST_PLL : ST_FETCH;
              cnt_q   <= 13'd0;
            end
          end
        end
        ST_PLL: begin
          pll_cnt_q <= pll_cnt_q + 16'd1;
          if (pll_cnt_q == 16'(`PLL_START_CYC - 1)) begin
            state_q <= seq_done_q ? ST_RUN : ST_FETCH; // and
          end
        end
        ST_FETCH: begin
          cnt_q <= cnt_q + 13'd1;
          if (cnt_q == 13'(`FETCH_CYCLES - 1)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (halt_wake && pll_enable) begin
            state_q   <= ST_PLL;
            pll_cnt_q <= 16'd0;
          end
        end
        default: state_q <= ST_ACTIVE;
      endcase
    end
  end

  // Sequence done flag; a wake restart of the PLL keeps the core running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_done_q <= 1'b0;
    end else if (any_src) begin
      seq_done_q <= 1'b0;
    end else if (state_q == ST_FETCH && cnt_q == 13'(`FETCH_CYCLES - 1)) begin
      seq_done_q <= 1'b1;
    end
  end

  // PLL startup begins on this edge, from the delay phase or a wake
  assign enter_pll = !any_src && pll_enable && (
    (state_q == ST_DELAY && cpu_clk_en && cnt_q == delay_len - 13'd1) ||
    (state_q == ST_RUN && halt_wake));

  // Reset pin drive and core reset; and
  assign rst_pin_o    = 1'b0;
  assign rst_pin_oe   = (state_q == ST_ACTIVE) || (state_q == ST_DELAY);
  assign core_reset_n = seq_done_q;
  assign vec_fetch    = (state_q == ST_FETCH);
  assign vec_addr     = `RESET_VECTOR_ADDR + {15'd0, cnt_q[0]};

  // Clock source selection
  assign osc_rc_sel  = opts.icc38 | (!opts.icc35 & (opts.src == SRC_RC));
  assign pll_enable  = opts.pll_on & !opts.icc38 & !opts.icc35;
  assign pll_mult8   = opts.pll_x8;
  assign osc_pll_sel = pll_enable & (state_q != ST_PLL);
  assign crystal_run = (opts.src == SRC_CRYSTAL);
  assign pll_halve_o = pll_halve_q;
  assign rc_trim     = {trim_hi_q, trim_lo_q}; // and
  assign clock_out_enable = main_ctl_q[`BIT_CLOCK_OUT_ENABLE];

  // Lock flag from PLL frequency detector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= pll_enable & pll_at_freq & !enter_pll &
                  (state_q == ST_FETCH || state_q == ST_RUN);
    end
  end

  // Slow divider; mode changes only at divider wrap, no runt enables; and
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q  <= 5'd0;
      slow_q <= 1'b0;
    end else begin
      div_q <= div_q + 5'd1;
      if (div_q == 5'd31) begin
        slow_q <= main_ctl_q[`BIT_SLOW_SELECT];
      end
    end
  end
  assign cpu_clk_en = !slow_q || (div_q == 5'd31);

  // AHB-Lite address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else if (hready) begin
      wr_q <= hsel & htrans[1] & hwrite;
      wa_q <= haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_ctl_q  <= `RST_MAIN_CLOCK_CONTROL;
      trim_hi_q   <= `RST_RC_TRIM_HIGH;
      trim_lo_q   <= `RST_TRIM_LOWER_BITS;
      pll_halve_q <= `RST_PLL_HALVE;
    end else if (!core_reset_n) begin
      main_ctl_q  <= `RST_MAIN_CLOCK_CONTROL;
      trim_hi_q   <= `RST_RC_TRIM_HIGH;
      trim_lo_q   <= `RST_TRIM_LOWER_BITS;
      pll_halve_q <= `RST_PLL_HALVE;
    end else if (wr_q) begin
      case (wa_q)
        `OFF_MAIN_CLOCK_CONTROL: main_ctl_q <= {6'd0, hwdata[1:0]};
        `OFF_RC_TRIM_HIGH:       trim_hi_q  <= hwdata[7:0];
        `OFF_INTEGRITY_CONTROL:  trim_lo_q  <= hwdata[6:5];
        `OFF_PLL_TEST_REG:       pll_halve_q <= hwdata[`BIT_PLL_HALVE];
        default: ;
      endcase
    end
  end

  // Read mux; unmapped reads zero
  always_comb begin
    rd_mux = 8'h00;
    case (wa_q)
      `OFF_MAIN_CLOCK_CONTROL: rd_mux = main_ctl_q;
      `OFF_RC_TRIM_HIGH:       rd_mux = trim_hi_q;
      `OFF_INTEGRITY_CONTROL:  rd_mux = {1'b0, trim_lo_q, 1'b0, locked_q, 3'b000};
      `OFF_PLL_TEST_REG:       rd_mux = {pll_halve_q, 7'd0};
      `OFF_SEQ_STATUS:         rd_mux = {5'd0, state_q};
      default:                 rd_mux = 8'h00;
    endcase
  end
  assign hrdata = {24'd0, rd_mux};

  // Checks
  a_trim_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    !core_reset_n |-> ##1 (trim_hi_q == 8'hFF)) else $error("trim not FFh in reset");
  a_pin_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_DELAY) |-> rst_pin_oe && !rst_pin_o) else $error("pin not low");
  a_fetch_two: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(vec_fetch) && !any_src) |-> (vec_addr == 16'hFFFE) ##1 (vec_addr == 16'hFFFF))
    else $error("bad vector fetch");
  a_slow_rate: assert property (@(posedge hclk) disable iff (!hresetn)
    (slow_q && cpu_clk_en && main_ctl_q[`BIT_SLOW_SELECT]) |-> ##1 !cpu_clk_en [*8])
    else $error("slow enable runt");
  a_mco_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    !core_reset_n |-> ##1 !clock_out_enable) else $error("clock out not cleared");
  a_icc_rc: assert property (@(posedge hclk) disable iff (!hresetn)
    opts.icc38 |-> osc_rc_sel && !pll_enable) else $error("icc rc not forced");
  a_pll_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_PLL) |-> !osc_pll_sel && !locked_q ##1 !locked_q) else $error("pll early");
  a_delay_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    any_src |-> ##1 (state_q == ST_ACTIVE)) else $error("no restart");

  // Vector address stays in the fixed pair
  a_fetch_addr: assert property (@(posedge hclk) disable iff (!hresetn)
    vec_fetch |-> (vec_addr[15:1] == 15'h7FFF)) else $error("vector outside pair");

  // Core held in reset while the pin is driven
  a_core_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_ACTIVE || state_q == ST_DELAY) |-> !core_reset_n) else $error("core early");

  // Delay counter stays below the chosen length
  a_delay_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_DELAY) |-> (cnt_q < delay_len)) else $error("delay overrun");

  // Startup phase only with the PLL enabled
  a_pll_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_PLL) |-> pll_enable) else $error("pll phase without pll");

  // Startup counter stays below its length
  a_pll_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_PLL) |-> (pll_cnt_q < 16'(`PLL_START_CYC))) else $error("pll overrun");

  // Lock only with the PLL on
  a_lock_src: assert property (@(posedge hclk) disable iff (!hresetn)
    locked_q |-> pll_enable) else $error("lock without pll");

  // Halve bit cleared by reset
  a_halve_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    !core_reset_n |-> ##1 !pll_halve_q) else $error("halve not cleared");

  // Clock control cleared by reset
  a_mode_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    !core_reset_n |-> ##1 (main_ctl_q == `RST_MAIN_CLOCK_CONTROL)) else $error("mode not cleared");

  // Crystal keeps running whatever the phase
  a_crystal_on: assert property (@(posedge hclk) disable iff (!hresetn)
    (opts.src == SRC_CRYSTAL) |-> crystal_run) else $error("crystal stopped");

  // Internal request puts the core in reset
  a_req_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    req_s2_q |-> ##1 !core_reset_n) else $error("request ignored");

  // Wake restarts the PLL without resetting the core
  a_wake_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_RUN && enter_pll) |-> ##1 (core_reset_n && state_q == ST_PLL))
    else $error("wake mishandled");

  // Pin low restarts the sequence
  a_ext_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    pin_s2_q |-> ##1 (state_q == ST_ACTIVE)) else $error("pin reset ignored");

  // Last fetch cycle releases the core
  a_fetch_end: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_FETCH && cnt_q == 13'd1 && !any_src) |-> ##1 core_reset_n)
    else $error("core not released");

  // PLL clock delivered once running
  a_pll_out: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_RUN && pll_enable) |-> osc_pll_sel) else $error("pll clock missing");

  // Tool clock entry keeps the PLL off
  a_icc_tool: assert property (@(posedge hclk) disable iff (!hresetn)
    (opts.icc35 && !opts.icc38) |-> !pll_enable) else $error("pll on in tool mode");

  // Lock cleared when startup begins
  a_lock_start: assert property (@(posedge hclk) disable iff (!hresetn)
    enter_pll |-> ##1 !locked_q) else $error("lock kept over startup");

  // Delay count starts from zero once sources release
  a_delay_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_ACTIVE && !any_src) |-> ##1 (state_q == ST_DELAY && cnt_q == 13'd0))
    else $error("delay not started");

  // Normal mode enables every cycle
  a_slow_pace: assert property (@(posedge hclk) disable iff (!hresetn)
    !slow_q |-> cpu_clk_en) else $error("normal mode gap");
endmodule

// *** verif/rst_pin_model.sv ***
// Reset pin circuitry model: weak pull-up, open-drain device, external pull-down
`timescale 1ns/10ps
module rst_pin_model (
  input  wire logic dev_o,
  input  wire logic dev_oe,
  input  wire logic ext_hold,
  output logic      pin
);
  // Wired level: low if either side pulls, else the pull-up wins
  assign pin = ((dev_oe && !dev_o) || ext_hold) ? 1'b0 : 1'b1;
endmodule

// *** verif/test_clock_and_reset_sequencer.sv ***
// Self-checking bench of the clock and reset sequencer
`timescale 1ns/10ps
`include "clk_rst_params.svh"
module test_clock_and_reset_sequencer;
  import clk_rst_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, halt_wake = 0;
  logic        pll_at_freq = 0, ext_hold = 0, hready, hreadyout, hresp;
  logic [7:0]  haddr = 8'h00, cal_byte;
  logic [1:0]  htrans = 2'h0, cal_sel = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  options_t    opts = '0;
  rst_req_t    reqs = '0;
  logic        rst_pin_i, rst_pin_o, rst_pin_oe, crystal_run, cpu_clk_en;
  logic        clock_out_enable, core_reset_n, vec_fetch, pll_halve_o;
  logic [9:0]  rc_trim;
  logic [15:0] vec_addr;
  int          error_cnt = 0, checks = 0;
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  clock_and_reset_sequencer dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hrdata, .hreadyout, .hresp, .hready, .opts, .reqs, .halt_wake,
    .pll_at_freq, .rst_pin_i, .rst_pin_o, .rst_pin_oe, .rc_trim, .osc_rc_sel(),
    .osc_pll_sel(), .pll_enable(), .pll_mult8(), .pll_halve_o, .crystal_run, .cpu_clk_en,
    .clock_out_enable, .core_reset_n, .vec_fetch, .vec_addr, .cal_sel, .cal_byte);
  rst_pin_model pin_u (.dev_o(rst_pin_o), .dev_oe(rst_pin_oe), .ext_hold, .pin(rst_pin_i));
  // Value compare with mismatch report
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // One AHB-Lite single word transfer
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task wait_run();
    int n;
    n = 0;
    while (core_reset_n !== 1'b1 && n < 6000) begin
      @(posedge hclk);
      n++;
    end
  endtask
  // Power reset, delay length, PLL startup, vector fetch
  task run_seq(input int dly, input int pll);
    int n;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("crystal_run", opts.src == SRC_CRYSTAL, crystal_run);
    hresetn <= 1'b1;
    n = 0;
    while (rst_pin_oe === 1'b1 && n < 5000) begin
      @(posedge hclk);
      n++;
    end
    chk("delay_len", 1, n >= dly && n <= dly + 8);
    n = 0;
    while (vec_fetch !== 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    chk("pll_delay", pll, n);
    chk("vec_addr", 16'hFFFE, vec_addr);
    n = 0;
    while (vec_fetch === 1'b1 && n < 10) begin
      @(posedge hclk);
      n++;
    end
    chk("fetch_len", 2, n);
    wait_run();
    chk("core_run", 1, core_reset_n);
    $display("run_seq %0d done", dly);
  endtask
  // Reset values and trim path
  task test_regs();
    bus(0, `OFF_MAIN_CLOCK_CONTROL, 0); chk("mcc_rst", 0, rd);
    bus(0, `OFF_RC_TRIM_HIGH, 0); chk("trim_rst", 32'hFF, rd);
    bus(0, `OFF_PLL_TEST_REG, 0); chk("halve_rst", 0, rd);
    chk("rc_trim_rst", 10'h3FF, rc_trim);
    bus(1, `OFF_RC_TRIM_HIGH, 32'h5A);
    bus(1, `OFF_INTEGRITY_CONTROL, 32'h40);
    bus(0, `OFF_RC_TRIM_HIGH, 0); chk("trim_rd", 32'h5A, rd);
    chk("rc_trim", 10'h16A, rc_trim);
    bus(0, 8'h20, 0); chk("unmapped", 0, rd);
    bus(1, 8'h20, 32'h3); bus(0, `OFF_MAIN_CLOCK_CONTROL, 0); chk("mcc_keep", 0, rd);
    $display("test_regs done");
  endtask
  // Slow mode, clock out, halve bit
  task test_clk();
    int c;
    for (int m = 1; m >= 0; m--) begin
      bus(1, `OFF_MAIN_CLOCK_CONTROL, {30'h0, m[0], m[0]});
      repeat (40) @(posedge hclk);
      c = 0;
      repeat (64) begin
        @(posedge hclk);
        c += cpu_clk_en;
      end
      chk("cpu_en_cnt", m ? 2 : 64, c);
      chk("clk_out", m[0], clock_out_enable);
    end
    bus(1, `OFF_PLL_TEST_REG, 32'h80);
    bus(0, `OFF_PLL_TEST_REG, 0); chk("halve_rd", 32'h80, rd);
    chk("halve_o", 1, pll_halve_o);
    for (int s = 1; s < 4; s += 2) begin
      cal_sel <= s[1:0];
      repeat (2) @(posedge hclk);
      chk("cal_low", 0, cal_byte & 8'h9F);
    end
    $display("test_clk done");
  endtask
  // Every reset source restarts the sequence
  task test_src();
    for (int i = 0; i < 4; i++) begin
      bus(1, `OFF_RC_TRIM_HIGH, 32'h12);
      @(posedge hclk);
      if (i < 3) reqs <= rst_req_t'(3'h1 << i);
      else ext_hold <= 1'b1;
      repeat (4) @(posedge hclk);
      chk("src_core", 0, core_reset_n);
      chk("src_pin", 1, rst_pin_oe);
      reqs <= '0;
      ext_hold <= 1'b0;
      @(posedge hclk);
      wait_run();
      bus(0, `OFF_RC_TRIM_HIGH, 0); chk("trim_again", 32'hFF, rd);
    end
    $display("test_src done");
  endtask
  // PLL startup, lock flag and wake restart
  task test_pll();
    opts <= '{src: SRC_RC, pll_on: 1'b1, pll_x8: 1'b1, default: 1'b0};
    run_seq(256, `PLL_START_CYC);
    pll_at_freq <= 1'b1;
    repeat (2) @(posedge hclk);
    bus(0, `OFF_INTEGRITY_CONTROL, 0); chk("locked", 32'h68, rd);
    halt_wake <= 1'b1;
    @(posedge hclk);
    halt_wake <= 1'b0;
    bus(0, `OFF_INTEGRITY_CONTROL, 0); chk("lock_wake", 32'h60, rd);
    chk("wake_core", 1, core_reset_n);
    repeat (`PLL_START_CYC + 4) @(posedge hclk);
    bus(0, `OFF_INTEGRITY_CONTROL, 0); chk("relock", 32'h68, rd);
    pll_at_freq <= 1'b0;
    $display("test_pll done");
  endtask
  task stop_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge hclk);
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge hclk);
    run_seq(256, 0);
    test_regs();
    test_clk();
    test_src();
    test_pll();
    opts <= '{src: SRC_CRYSTAL, default: 1'b0};
    run_seq(4096, 0);
    stop_test();
  end
endmodule
